// >>> verilog/ccr_register_bank.sv
// Functional notes
// - Respond only to 7-bit slave address 07H; other addresses are ignored.
// - Eleven 8-bit registers 0x00-0x0A; 0x08 read-only, 0x0A not host accessible.
// - Power-on defaults 9F AC 0F 91 A3 3A C0 39 40 00 E0.
// - Register 0x00 bits 7:4 hold the input voltage floor, default 1001.
// - Register 0x00 bits 3:0 hold the input current cap, default 1111.
// - Writing 1 to 0x02 bit 7 restores all register defaults; bit reads 0.
// - Register 0x01 bits 7:6 select alert-low debounce 8/12/16/20 s.
// - Register 0x01 bit 5 selects battery off duration 2 s or 4 s.
// - Register 0x01 bit 4 enables input high-impedance, regulator switch only.
// - Register 0x01 bit 3 is charge inhibit, power-on value 1.
// - Register 0x01 bits 2:0 hold the battery cutoff threshold, default 100.
// - Register 0x02 bits 5:0 hold fast charge current, default 001111.
// - Register 0x03 holds discharge cap (7:4) and termination current (3:0).
// - Undefined register offset is answered with NACK and return to idle.
// - Reads are one byte: write address, offset, repeated start, read, NACK, stop.
module ccr_register_bank (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // serial pins, open drain
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  output logic                  o_sda_out,
  output logic                  o_sda_oe,
  // charger core side
  input  wire logic [7:0]       i_status,
  input  wire logic [7:0]       i_fault,
  output ccr_pkg::ccr_cfg_s     o_cfg
);
  import ccr_pkg::*;

  ccr_state_s st;
  ccr_state_s next_st;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic ofs_valid(input logic [7:0] ofs);
    return ofs < 8'(NUM_REGS) && ofs != OFS_ADDR_CFG;
  endfunction : ofs_valid

  function automatic ccr_regs_t defaults();
    ccr_regs_t r;
    r = '0;
    r[0]  = RST_INPUT_SRC;
    r[1]  = RST_POWER_ON;
    r[2]  = RST_CHG_CURR;
    r[3]  = RST_DSCHG_TERM;
    r[4]  = RST_CHG_VOLT;
    r[5]  = RST_TERM_TMR;
    r[6]  = RST_MISC;
    r[7]  = RST_SYS_VREG;
    r[8]  = RST_STATUS;
    r[9]  = RST_FAULT;
    r[10] = RST_ADDR_CFG;
    return r;
  endfunction : defaults

  function automatic ccr_cfg_s decode(input ccr_regs_t r);
    ccr_cfg_s c;
    c = '0;
    c.input_voltage_floor      = r[0][7:POS_VFLOOR_LSB];
    c.input_current_cap        = r[0][POS_VFLOOR_LSB-1:0];
    c.disconnect_debounce_sel  = r[1][7:POS_DGL_LSB];
    c.off_duration_sel         = r[1][POS_OFF_DUR];
    c.input_highz_enable       = r[1][POS_HIGHZ];
    c.charge_inhibit           = r[1][POS_INHIBIT];
    c.battery_cutoff_threshold = r[1][POS_INHIBIT-1:0];
    c.fast_charge_current      = r[2][5:0];
    c.discharge_current_cap    = r[3][7:POS_DCAP_LSB];
    c.termination_current      = r[3][POS_DCAP_LSB-1:0];
    return c;
  endfunction : decode

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;

  always_comb begin
    scl_rise   = st.scl_sync[1] & ~st.scl_q;
    scl_fall   = ~st.scl_sync[1] & st.scl_q;
    start_cond = st.scl_sync[1] & st.scl_q & st.sda_q & ~st.sda_sync[1];
    stop_cond  = st.scl_sync[1] & st.scl_q & ~st.sda_q & st.sda_sync[1];
    byte_done  = scl_fall && st.bit_cnt == 4'h8 && !start_cond && !stop_cond;
  end

  // ----------------------------------------
  // serial slave and register file
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.scl_sync = {st.scl_sync[0], i_scl};
    next_st.sda_sync = {st.sda_sync[0], i_sda};
    next_st.scl_q    = st.scl_sync[1];
    next_st.sda_q    = st.sda_sync[1];
    if (start_cond) begin
      next_st.state   = CCR_ADDR;
      next_st.bit_cnt = '0;
      next_st.sda_oe  = 1'b0;
    end else if (stop_cond) begin
      next_st.state  = CCR_IDLE;
      next_st.sda_oe = 1'b0;
    end else begin
      unique case (st.state)
        CCR_IDLE, CCR_IGNORE: begin
          next_st.sda_oe = 1'b0;
        end
        CCR_ADDR, CCR_OFS, CCR_WDATA: begin
          if (scl_rise) begin
            next_st.shreg   = {st.shreg[6:0], st.sda_sync[1]};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end
          if (scl_fall && st.bit_cnt == 4'h8) begin
            next_st.bit_cnt = '0;
            if (st.state == CCR_ADDR) begin
              if (st.shreg[7:1] == SLAVE_ADDR) begin
                next_st.is_read = st.shreg[0];
                next_st.sda_oe  = 1'b1;
                next_st.state   = CCR_ADDR_ACK;
              end else begin
                next_st.state = CCR_IGNORE;
              end
            end else if (st.state == CCR_OFS) begin
              next_st.offset = st.shreg;
              if (ofs_valid(st.shreg)) begin
                next_st.sda_oe = 1'b1;
                next_st.state  = CCR_OFS_ACK;
              end else begin
                next_st.state = CCR_IDLE;
              end
            end else begin
              next_st.sda_oe = 1'b1;
              next_st.state  = CCR_WDATA_ACK;
              if (st.offset == OFS_CHG_CURR && st.shreg[POS_REG_RESET]) begin
                next_st.regs = defaults();
              end else if (st.offset != OFS_STATUS && st.offset != OFS_ADDR_CFG) begin
                next_st.regs[st.offset[3:0]] = st.shreg;
              end
            end
          end
        end
        CCR_ADDR_ACK, CCR_OFS_ACK, CCR_WDATA_ACK: begin
          if (scl_fall) begin
            next_st.sda_oe = 1'b0;
            if (st.state == CCR_ADDR_ACK && st.is_read) begin
              next_st.shreg  = st.regs[st.offset[3:0]];
              next_st.sda_oe = ~st.regs[st.offset[3:0]][7];
              next_st.state  = CCR_RDATA;
            end else if (st.state == CCR_ADDR_ACK) begin
              next_st.state = CCR_OFS;
            end else if (st.state == CCR_OFS_ACK) begin
              next_st.state = CCR_WDATA;
            end else begin
              next_st.state = CCR_IGNORE;   // single write only
            end
          end
        end
        CCR_RDATA: begin
          if (scl_fall) begin
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            if (st.bit_cnt == 4'h7) begin
              next_st.sda_oe = 1'b0;
              next_st.state  = CCR_RDATA_ACK;
            end else begin
              next_st.shreg  = {st.shreg[6:0], 1'b0};
              next_st.sda_oe = ~st.shreg[6];
            end
          end
        end
        CCR_RDATA_ACK: begin
          // one byte per read whatever the master answers
          if (scl_fall) begin
            next_st.state = CCR_IGNORE;
          end
        end
      endcase
    end
    // core bits applied last: neither a host write nor a register reset may mask them
    next_st.regs[8] = i_status;
    next_st.regs[9] = next_st.regs[9] | i_fault;
    next_st.cfg = decode(next_st.regs);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st          <= '0;
      st.scl_sync <= 2'b11;
      st.sda_sync <= 2'b11;
      st.scl_q    <= 1'b1;
      st.sda_q    <= 1'b1;
      st.state    <= CCR_IDLE;
      st.regs     <= defaults();
      st.cfg      <= decode(defaults());
    end else begin
      st <= next_st;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe  = st.sda_oe;
  assign o_cfg     = st.cfg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_inhibit_default;
    @(posedge i_clk) $fell(i_sys_rst) |-> o_cfg.charge_inhibit;
  endproperty
  a_inhibit_default: assert property (p_inhibit_default) else $error("inhibit not set after reset");

  property p_floor_default;
    @(posedge i_clk) $fell(i_sys_rst) |-> o_cfg.input_voltage_floor == 4'h9 && o_cfg.input_current_cap == 4'hf;
  endproperty
  a_floor_default: assert property (p_floor_default) else $error("input defaults wrong");

  property p_status_ro;
    @(posedge i_clk) disable iff (i_sys_rst) 1'b1 |=> st.regs[8] == $past(i_status);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status not mirrored");

  property p_addr_cfg_fixed;
    @(posedge i_clk) disable iff (i_sys_rst) st.regs[10] == RST_ADDR_CFG;
  endproperty
  a_addr_cfg_fixed: assert property (p_addr_cfg_fixed) else $error("address register changed");

  property p_bad_ofs_nack;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st.state == CCR_OFS && scl_fall && st.bit_cnt == 4'h8 && !ofs_valid(st.shreg) && !start_cond && !stop_cond)
      |=> st.state == CCR_IDLE && !o_sda_oe;
  endproperty
  a_bad_ofs_nack: assert property (p_bad_ofs_nack) else $error("undefined offset acked");

  property p_addr_ack;
    @(posedge i_clk) disable iff (i_sys_rst) (st.state == CCR_ADDR_ACK) |-> o_sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no ack for own address");

  property p_reg_reset;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st.state == CCR_WDATA && scl_fall && st.bit_cnt == 4'h8 && st.offset == OFS_CHG_CURR
       && st.shreg[POS_REG_RESET] && !start_cond && !stop_cond)
      |=> st.regs[2] == RST_CHG_CURR ##1 o_cfg.charge_inhibit && o_cfg.fast_charge_current == 6'h0f;
  endproperty
  a_reg_reset: assert property (p_reg_reset) else $error("register reset failed");

  sequence s_read_end;
    st.state == CCR_RDATA_ACK ##1 (st.state == CCR_RDATA_ACK || st.state == CCR_IGNORE);
  endsequence
  property p_single_read;
    @(posedge i_clk) disable iff (i_sys_rst) s_read_end |-> !o_sda_oe;
  endproperty
  a_single_read: assert property (p_single_read) else $error("drives sda after read byte");

  // ----------------------------------------
  // write path checks
  // ----------------------------------------
  // a full byte taken while receiving data; start and stop take priority
  sequence s_wdata_in;
    st.state == CCR_WDATA && byte_done;
  endsequence

  property p_wr_input_src;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_wdata_in ##0 (st.offset == OFS_INPUT_SRC)
      |=> st.regs[0] == $past(st.shreg) && o_cfg.input_current_cap == $past(st.shreg[3:0]);
  endproperty
  a_wr_input_src: assert property (p_wr_input_src) else $error("input source write lost");

  property p_wr_power_on;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_wdata_in ##0 (st.offset == OFS_POWER_ON)
      |=> o_cfg.disconnect_debounce_sel == $past(st.shreg[7:6]) && o_cfg.off_duration_sel == $past(st.shreg[5])
          && o_cfg.input_highz_enable == $past(st.shreg[4]) && o_cfg.charge_inhibit == $past(st.shreg[3])
          && o_cfg.battery_cutoff_threshold == $past(st.shreg[2:0]);
  endproperty
  a_wr_power_on: assert property (p_wr_power_on) else $error("config write lost");

  property p_wr_chg_curr;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_wdata_in ##0 (st.offset == OFS_CHG_CURR && !st.shreg[POS_REG_RESET])
      |=> o_cfg.fast_charge_current == $past(st.shreg[5:0]);
  endproperty
  a_wr_chg_curr: assert property (p_wr_chg_curr) else $error("charge current write lost");

  property p_wr_dschg;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_wdata_in ##0 (st.offset == OFS_DSCHG_TERM)
      |=> o_cfg.discharge_current_cap == $past(st.shreg[7:4]) && o_cfg.termination_current == $past(st.shreg[3:0]);
  endproperty
  a_wr_dschg: assert property (p_wr_dschg) else $error("discharge write lost");

  property p_wr_status_kept;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_wdata_in ##0 (st.offset == OFS_STATUS) |=> st.regs[8] == $past(i_status);
  endproperty
  a_wr_status_kept: assert property (p_wr_status_kept) else $error("status overwritten by host");

  // the reset request never sticks, so it cannot fire twice
  property p_reset_bit_low;
    @(posedge i_clk) disable iff (i_sys_rst) st.regs[2][POS_REG_RESET] == 1'b0;
  endproperty
  a_reset_bit_low: assert property (p_reset_bit_low) else $error("reset bit stored");

  property p_fault_sticky;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_fault != 8'h00) |=> (st.regs[9] & $past(i_fault)) == $past(i_fault);
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault event lost");

  property p_extra_byte_nack;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st.state == CCR_WDATA_ACK && scl_fall && !start_cond && !stop_cond)
      |=> st.state == CCR_IGNORE && !o_sda_oe;
  endproperty
  a_extra_byte_nack: assert property (p_extra_byte_nack) else $error("second data byte taken");

  property p_ignore_silent;
    @(posedge i_clk) disable iff (i_sys_rst) (st.state == CCR_IGNORE) |-> !o_sda_oe;
  endproperty
  a_ignore_silent: assert property (p_ignore_silent) else $error("sda driven while ignoring");

  property p_foreign_addr;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st.state == CCR_ADDR && byte_done && st.shreg[7:1] != SLAVE_ADDR)
      |=> st.state == CCR_IGNORE && !o_sda_oe;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address answered");

  property p_cfg_default;
    @(posedge i_clk) $fell(i_sys_rst) |-> o_cfg.disconnect_debounce_sel == 2'h2 && o_cfg.off_duration_sel
      && !o_cfg.input_highz_enable && o_cfg.battery_cutoff_threshold == 3'h4 && o_cfg.fast_charge_current == 6'h0f
      && o_cfg.discharge_current_cap == 4'h9 && o_cfg.termination_current == 4'h1;
  endproperty
  a_cfg_default: assert property (p_cfg_default) else $error("config defaults wrong");

  // ----------------------------------------
  // read path checks
  // ----------------------------------------
  sequence s_read_ack_end;
    st.state == CCR_ADDR_ACK && st.is_read && scl_fall && !start_cond && !stop_cond;
  endsequence

  property p_read_first_bit;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_read_ack_end |=> st.state == CCR_RDATA && o_sda_oe == !$past(st.regs[st.offset[3:0]][7]);
  endproperty
  a_read_first_bit: assert property (p_read_first_bit) else $error("read msb wrong");

  property p_ofs_ack;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st.state == CCR_OFS && byte_done && ofs_valid(st.shreg)) |=> st.state == CCR_OFS_ACK && o_sda_oe;
  endproperty
  a_ofs_ack: assert property (p_ofs_ack) else $error("defined offset not acked");

  property p_rdata_release;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st.state == CCR_RDATA && scl_fall && st.bit_cnt == 4'h7 && !start_cond && !stop_cond)
      |=> st.state == CCR_RDATA_ACK && !o_sda_oe;
  endproperty
  a_rdata_release: assert property (p_rdata_release) else $error("sda held into host ack");

endmodule : ccr_register_bank

// >>> pkg/ccr_pkg.sv
package ccr_pkg;

  // ----------------------------------------
  // slave address and register map
  // ----------------------------------------
  localparam logic [6:0] SLAVE_ADDR     = 7'h07;
  localparam logic [7:0] OFS_INPUT_SRC  = 8'h00;
  localparam logic [7:0] OFS_POWER_ON   = 8'h01;
  localparam logic [7:0] OFS_CHG_CURR   = 8'h02;
  localparam logic [7:0] OFS_DSCHG_TERM = 8'h03;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_FAULT      = 8'h09;
  localparam logic [7:0] OFS_ADDR_CFG   = 8'h0a;
  localparam int         NUM_REGS       = 11;

  // ----------------------------------------
  // power-on values
  // ----------------------------------------
  localparam logic [7:0] RST_INPUT_SRC  = 8'h9f;
  localparam logic [7:0] RST_POWER_ON   = 8'hac;
  localparam logic [7:0] RST_CHG_CURR   = 8'h0f;
  localparam logic [7:0] RST_DSCHG_TERM = 8'h91;
  localparam logic [7:0] RST_CHG_VOLT   = 8'ha3;
  localparam logic [7:0] RST_TERM_TMR   = 8'h3a;
  localparam logic [7:0] RST_MISC       = 8'hc0;
  localparam logic [7:0] RST_SYS_VREG   = 8'h39;
  localparam logic [7:0] RST_STATUS     = 8'h40;
  localparam logic [7:0] RST_FAULT      = 8'h00;
  localparam logic [7:0] RST_ADDR_CFG   = 8'he0;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int POS_VFLOOR_LSB  = 4;
  localparam int POS_REG_RESET   = 7;
  localparam int POS_DGL_LSB     = 6;
  localparam int POS_OFF_DUR     = 5;
  localparam int POS_HIGHZ       = 4;
  localparam int POS_INHIBIT     = 3;
  localparam int POS_DCAP_LSB    = 4;

  typedef enum logic [3:0] {
    CCR_IDLE, CCR_ADDR, CCR_ADDR_ACK, CCR_OFS, CCR_OFS_ACK,
    CCR_WDATA, CCR_WDATA_ACK, CCR_RDATA, CCR_RDATA_ACK, CCR_IGNORE
  } ccr_state_e;

  // decoded settings driven to the charger core
  typedef struct packed {
    logic [3:0] input_voltage_floor;
    logic [3:0] input_current_cap;
    logic [1:0] disconnect_debounce_sel;
    logic       off_duration_sel;
    logic       input_highz_enable;
    logic       charge_inhibit;
    logic [2:0] battery_cutoff_threshold;
    logic [5:0] fast_charge_current;
    logic [3:0] discharge_current_cap;
    logic [3:0] termination_current;
  } ccr_cfg_s;

  typedef logic [NUM_REGS-1:0][7:0] ccr_regs_t;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_q;
    logic       sda_q;
    ccr_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] offset;
    logic       is_read;
    logic       sda_oe;
    ccr_regs_t  regs;
    ccr_cfg_s   cfg;
  } ccr_state_s;

endpackage : ccr_pkg

// >>> tb/ccr_i2c_host.sv
module ccr_i2c_host (
  // clock and serial bus
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  // half period well above the slave's synchroniser delay
  localparam int HALF = 12;

  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end

  task automatic half_bit();
    repeat (HALF) @(negedge i_clk);
  endtask : half_bit

  // sda is only moved a few cycles after scl falls, so the slave never sees both change together
  task automatic scl_low();
    o_scl = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask : scl_low

  // ----------------------------------------
  // bus conditions
  // ----------------------------------------
  task automatic start();
    o_sda_pull = 1'b0;
    half_bit();
    o_scl = 1'b1;
    half_bit();
    o_sda_pull = 1'b1;
    half_bit();
    scl_low();
  endtask : start

  task automatic stop();
    o_sda_pull = 1'b1;
    half_bit();
    o_scl = 1'b1;
    half_bit();
    o_sda_pull = 1'b0;
    half_bit();
  endtask : stop

  // nine clocks, msb first; a 1 in tx releases the line so the slave may drive it
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      o_sda_pull = ~tx[i];
      half_bit();
      o_scl = 1'b1;
      half_bit();
      rx[i] = i_sda;
      scl_low();
    end
  endtask : xfer
endmodule : ccr_i2c_host

// >>> tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ccr_pkg::*;

  logic         i_clk;
  logic         i_sys_rst;
  logic [7:0]   i_status;
  logic [7:0]   i_fault;
  logic         o_sda_out;
  logic         o_sda_oe;
  ccr_cfg_s     o_cfg;
  logic         scl;
  logic         pull;
  wire logic    sda;
  int           n_errors;
  int           check_count;
  logic [7:0]   m [4];
  logic [8:0]   a;
  localparam logic [7:0] HI_RST [6] = '{RST_CHG_VOLT, RST_TERM_TMR, RST_MISC, RST_SYS_VREG, RST_STATUS, RST_FAULT};
  localparam logic [7:0] PWR_TAB [4] = '{8'h07, 8'h50, 8'h9a, 8'hf5};

  // open drain line with pull-up
  assign sda = !(pull || (o_sda_oe && !o_sda_out));

  ccr_register_bank ccr_register_bank_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_status(i_status), .i_fault(i_fault), .o_cfg(o_cfg));
  ccr_i2c_host ccr_i2c_host_i (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [29:0] got, input logic [29:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input logic exp_ack);
    logic [8:0] b, c, e;
    ccr_i2c_host_i.start();
    ccr_i2c_host_i.xfer({SLAVE_ADDR, 1'b0, 1'b1}, b);
    ccr_i2c_host_i.xfer({ofs, 1'b1}, c);
    ccr_i2c_host_i.xfer({d, 1'b1}, e);
    ccr_i2c_host_i.stop();
    chk(30'(!b[0] && !c[0] && !e[0]), 30'(exp_ack));
  endtask : wr

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic [8:0] b, c, e, r;
    ccr_i2c_host_i.start();
    ccr_i2c_host_i.xfer({SLAVE_ADDR, 1'b0, 1'b1}, b);
    ccr_i2c_host_i.xfer({ofs, 1'b1}, c);
    ccr_i2c_host_i.start();
    ccr_i2c_host_i.xfer({SLAVE_ADDR, 1'b1, 1'b1}, e);
    ccr_i2c_host_i.xfer(9'h1ff, r);
    ccr_i2c_host_i.stop();
    chk(30'({b[0], c[0], e[0]}), 30'h0);
    chk(30'(r[8:1]), 30'(exp));
  endtask : rd

  // settings registers read back and seen on the config port
  task automatic check_all();
    for (int i = 0; i < 4; i++) begin
      rd(8'(i), m[i]);
    end
    chk(o_cfg, {m[0], m[1], m[2][5:0], m[3]});
  endtask : check_all

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    i_sys_rst   = 1'b1;
    i_status    = RST_STATUS;
    i_fault     = 8'h00;
    n_errors    = 0;
    check_count = 0;
    m = '{RST_INPUT_SRC, RST_POWER_ON, RST_CHG_CURR, RST_DSCHG_TERM};
    repeat (5) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    check_all();
    for (int i = 0; i < 6; i++) begin
      rd(8'(i + 4), HI_RST[i]);
    end
    wr(OFS_INPUT_SRC, 8'h5a, 1'b1);
    m[0] = 8'h5a;
    for (int k = 0; k < 4; k++) begin
      wr(OFS_POWER_ON, PWR_TAB[k], 1'b1);
      m[1] = PWR_TAB[k];
      check_all();
    end
    wr(OFS_CHG_CURR, 8'h38, 1'b1);
    m[2] = 8'h38;
    // lowest valid discharge cap code, the host never writes 0000
    wr(OFS_DSCHG_TERM, 8'h1f, 1'b1);
    m[3] = 8'h1f;
    check_all();
    i_status = 8'h3c;
    wr(OFS_STATUS, 8'ha5, 1'b1);
    rd(OFS_STATUS, 8'h3c);
    wr(8'h0b, 8'h00, 1'b0);
    rd(OFS_POWER_ON, m[1]);
    ccr_i2c_host_i.start();
    ccr_i2c_host_i.xfer({7'h08, 1'b0, 1'b1}, a);
    ccr_i2c_host_i.stop();
    chk(30'(a[0]), 30'h1);
    i_fault = 8'h04;
    @(negedge i_clk);
    i_fault = 8'h00;
    rd(OFS_FAULT, 8'h04);
    wr(OFS_FAULT, 8'h00, 1'b1);
    rd(OFS_FAULT, 8'h00);
    wr(OFS_CHG_CURR, 8'h80, 1'b1);
    m = '{RST_INPUT_SRC, RST_POWER_ON, RST_CHG_CURR, RST_DSCHG_TERM};
    check_all();
    // reset in mid-run must bring back the power-on values
    wr(OFS_POWER_ON, 8'h07, 1'b1);
    i_sys_rst = 1'b1;
    repeat (5) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    check_all();
    stop_test();
  end

  // the sequence needs about 57500 cycles
  initial begin
    repeat (90000) @(posedge i_clk);
    n_errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : tb
